// *** src/lbf_pkg.sv ***
// constants, opcode patterns and op kinds of the loop/branch/flag unit
// assumes one 10 MHz system clock; one machine state takes one clock cycle
package lbf_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_W = 8;
  localparam int MS_W = 4;
  localparam int FINFO_W = 6;
  localparam int LONG_OFF_W = 16;
  localparam int SHORT_OFF_W = 5;
  localparam int BIT_SHIFT = 4;

  // ----------------------------------------------------------------
  // register port offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_COUNTER = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_EXEC = 8'h0C;
  localparam logic [WORD_W-1:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] COUNTER_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // flag_word field positions
  // ----------------------------------------------------------------
  localparam int FLAG_Z_BIT = 29;
  localparam int FLAG_NCZV_LSB = 28;
  localparam int FLAG_GIE_BIT = 21;
  localparam int FLD1_LSB = 6;
  localparam int FLD0_LSB = 0;

  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam logic [10:0] OPC_DEC_LONG = 11'h06C;
  localparam logic [10:0] OPC_DEC_ZSET = 11'h06D;
  localparam logic [10:0] OPC_DEC_ZCLR = 11'h06E;
  localparam logic [10:0] OPC_DEBUG = 11'h008;
  localparam logic [4:0] OPC_DEC_SHORT = 5'h07;
  localparam logic [15:0] OPC_IRQ_ON = 16'h0D60;
  localparam logic [15:0] OPC_IRQ_OFF = 16'h0360;
  localparam logic [5:0] OPC_SWAP_HI = 6'h35;
  localparam logic [3:0] OPC_SWAP_LO = 4'h8;
  localparam int SWAP_SEL_BIT = 9;
  localparam int SHORT_DIR_BIT = 10;
  localparam int SHORT_OFF_LSB = 5;

  // ----------------------------------------------------------------
  // machine state counts
  // ----------------------------------------------------------------
  localparam logic [MS_W-1:0] MS_LOOP_SKIP = 4'h2;
  localparam logic [MS_W-1:0] MS_LOOP_JUMP = 4'h3;
  localparam logic [MS_W-1:0] MS_IRQ_ON = 4'h3;
  localparam logic [MS_W-1:0] MS_IRQ_OFF = 4'h3;
  localparam logic [MS_W-1:0] MS_DEBUG = 4'h8;
  localparam logic [MS_W-1:0] MS_SWAP_F0 = 4'h1;
  localparam logic [MS_W-1:0] MS_SWAP_F1 = 4'h2;

  typedef enum {
    OP_NONE, OP_DEC_LONG, OP_DEC_ZSET, OP_DEC_ZCLR, OP_DEC_SHORT,
    OP_IRQ_ON, OP_IRQ_OFF, OP_DEBUG, OP_FIELD_SWAP
  } lbf_op_t;

endpackage : lbf_pkg

// *** src/lbf_core_if.sv ***
// signals between the execution core, its branch adder and its state timer
// assumes all three sit on the same clock
`timescale 1ns/100ps
interface lbf_core_if;
  import lbf_pkg::*;
  logic [WORD_W-1:0] pc_next;
  logic [LONG_OFF_W-1:0] long_off;
  logic [SHORT_OFF_W-1:0] short_off;
  logic short_back;
  logic short_sel;
  logic [WORD_W-1:0] target;
  logic load;
  logic [MS_W-1:0] states;
  logic busy;
  logic done;
  modport core (output pc_next, long_off, short_off, short_back, short_sel, load, states,
    input target, busy, done);
  modport adder (input pc_next, long_off, short_off, short_back, short_sel, output target);
  modport timer (input load, states, output busy, done);
endinterface : lbf_core_if

// *** src/lbf_branch_adder.sv ***
// branch target adder for long and short loop branches
// assumes pc_next already points past the whole instruction
`timescale 1ns/100ps
module lbf_branch_adder import lbf_pkg::*; (
  // operands and result
  lbf_core_if.adder cif
);

  function automatic logic [WORD_W-1:0] words_to_bits(input logic [WORD_W-BIT_SHIFT-1:0] w);
    words_to_bits = {w, {BIT_SHIFT{1'b0}}};
  endfunction : words_to_bits

  logic [WORD_W-1:0] long_bits;
  logic [WORD_W-1:0] short_bits;

  // full 16-bit signed span kept by sign extension
  assign long_bits = words_to_bits({{(WORD_W-BIT_SHIFT-LONG_OFF_W){cif.long_off[LONG_OFF_W-1]}},
    cif.long_off});
  assign short_bits = words_to_bits({{(WORD_W-BIT_SHIFT-SHORT_OFF_W){1'b0}}, cif.short_off});

  // direction bit picks add or subtract
  // reach limited by the five-bit magnitude
  assign cif.target = !cif.short_sel ? cif.pc_next + long_bits :
    (cif.short_back ? cif.pc_next - short_bits : cif.pc_next + short_bits);

endmodule : lbf_branch_adder

// *** src/lbf_state_timer.sv ***
// counts machine states of one instruction and pulses done on the last one
// assumes load only arrives while busy is low
`timescale 1ns/100ps
module lbf_state_timer import lbf_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // load and status
  lbf_core_if.timer cif
);

  logic [MS_W-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  // done lands exactly states cycles after the load cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (cif.load) begin
      cnt_ff <= cif.states;
      busy_ff <= (cif.states != MS_SWAP_F0);
      done_ff <= (cif.states == MS_SWAP_F0);
    end else if (cnt_ff == MS_LOOP_SKIP) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b1;
    end else begin
      cnt_ff <= (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
      done_ff <= 1'b0;
    end
  end

  assign cif.busy = busy_ff;
  assign cif.done = done_ff;

endmodule : lbf_state_timer

// *** src/lbf_exec_core.sv ***
// execution unit for loop branches, interrupt enable, debug entry and field swap
// assumes one issued instruction word at a time, held beside op_valid for one cycle
`timescale 1ns/100ps
module lbf_exec_core import lbf_pkg::*; #(
  parameter int IRQ_N = 16,
  parameter logic [MS_W-1:0] DEBUG_EXTRA = 4'h4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // instruction issue
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [LONG_OFF_W-1:0] op_ext,
  input wire logic [WORD_W-1:0] pc_next,
  output logic op_busy,
  // completion
  output logic op_done,
  output logic jump_taken,
  output logic [WORD_W-1:0] jump_target,
  // debug control
  input wire logic debug_permit,
  input wire logic debug_release,
  output logic debug_mode,
  // interrupts
  input wire logic [IRQ_N-1:0] irq_src,
  output logic irq_request,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [WORD_W-1:0] reg_rdata
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (IRQ_N < 1 || IRQ_N > WORD_W) begin : g_bad_irq_n
    $error("IRQ_N must be 1 to 32");
  end
  if (int'(MS_DEBUG) + int'(DEBUG_EXTRA) > 15) begin : g_bad_extra
    $error("DEBUG_EXTRA overflows the state timer");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic lbf_op_t decode(input logic [15:0] w);
    decode = OP_NONE;
    if (w[15:5] == OPC_DEC_LONG) decode = OP_DEC_LONG;
    else if (w[15:5] == OPC_DEC_ZSET) decode = OP_DEC_ZSET;
    else if (w[15:5] == OPC_DEC_ZCLR) decode = OP_DEC_ZCLR;
    else if (w[15:11] == OPC_DEC_SHORT) decode = OP_DEC_SHORT;
    else if (w == OPC_IRQ_ON) decode = OP_IRQ_ON;
    else if (w == OPC_IRQ_OFF) decode = OP_IRQ_OFF;
    else if (w[15:5] == OPC_DEBUG) decode = OP_DEBUG;
    else if (w[15:10] == OPC_SWAP_HI && w[8:5] == OPC_SWAP_LO) decode = OP_FIELD_SWAP;
  endfunction : decode

  lbf_core_if cif ();

  logic [WORD_W-1:0] flag_word_ff;
  logic [WORD_W-1:0] counter_ff;
  logic [WORD_W-1:0] irq_mask_ff;
  logic jump_taken_ff;
  logic [WORD_W-1:0] jump_target_ff;
  logic debug_mode_ff;
  logic irq_request_ff;
  logic [WORD_W-1:0] reg_rdata_ff;
  logic [IRQ_N-1:0] irq_s1_ff;
  logic [IRQ_N-1:0] irq_s2_ff;
  logic [IRQ_N-1:0] irq_s3_ff;
  logic [IRQ_N-1:0] irq_level_ff;

  logic issue;
  lbf_op_t kind;
  logic is_loop;
  logic dec_en;
  logic [WORD_W-1:0] dec_val;
  logic taken;
  logic swap_sel;
  logic [FINFO_W-1:0] old_info;
  logic debug_enter;

  // a word offered while busy is ignored; the issuer watches op_busy
  assign issue = op_valid && !cif.busy;
  assign kind = issue ? decode(op_word) : OP_NONE;
  assign is_loop = kind inside {OP_DEC_LONG, OP_DEC_ZSET, OP_DEC_ZCLR, OP_DEC_SHORT};
  assign swap_sel = op_word[SWAP_SEL_BIT];
  assign debug_enter = (kind == OP_DEBUG) && debug_permit;

  // zero-clear form gated by not Z
  assign dec_en = (kind == OP_DEC_LONG) || (kind == OP_DEC_SHORT) ||
    ((kind == OP_DEC_ZSET) && flag_word_ff[FLAG_Z_BIT]) ||
    ((kind == OP_DEC_ZCLR) && !flag_word_ff[FLAG_Z_BIT]);
  // plain wrap from zero to all ones
  assign dec_val = counter_ff - 32'h0000_0001;
  assign taken = dec_en && (dec_val != '0);

  // extension in bit 5, size below
  assign old_info = swap_sel ? flag_word_ff[FLD1_LSB +: FINFO_W] :
    flag_word_ff[FLD0_LSB +: FINFO_W];

  // ----------------------------------------------------------------
  // branch target and timing
  // ----------------------------------------------------------------
  assign cif.pc_next = pc_next;
  assign cif.long_off = op_ext;
  assign cif.short_off = op_word[SHORT_OFF_LSB +: SHORT_OFF_W];
  assign cif.short_back = op_word[SHORT_DIR_BIT];
  assign cif.short_sel = (kind == OP_DEC_SHORT);
  assign cif.load = (kind != OP_NONE);

  // two states falling through, three jumping
  // debug entry takes extra states when entered
  always_comb begin
    cif.states = MS_SWAP_F0;
    unique case (kind)
      OP_NONE: cif.states = MS_SWAP_F0;
      OP_DEC_LONG, OP_DEC_ZSET, OP_DEC_ZCLR, OP_DEC_SHORT:
        cif.states = taken ? MS_LOOP_JUMP : MS_LOOP_SKIP;
      OP_IRQ_ON: cif.states = MS_IRQ_ON;
      OP_IRQ_OFF: cif.states = MS_IRQ_OFF;
      OP_DEBUG: cif.states = debug_enter ? MS_DEBUG + DEBUG_EXTRA : MS_DEBUG;
      OP_FIELD_SWAP: cif.states = swap_sel ? MS_SWAP_F1 : MS_SWAP_F0;
    endcase
  end

  lbf_branch_adder u_adder (
    .cif(cif.adder)
  );

  lbf_state_timer u_timer (
    .clock(clock),
    .rst(rst),
    .cif(cif.timer)
  );

  // ----------------------------------------------------------------
  // counter register
  // ----------------------------------------------------------------
  // instruction updates win over a software write in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      counter_ff <= COUNTER_RESET;
    end else if (dec_en) begin
      counter_ff <= dec_val;
    end else if (kind == OP_FIELD_SWAP) begin
      // six bits in, upper bits cleared
      counter_ff <= {{(WORD_W-FINFO_W){1'b0}}, old_info};
    end else if (reg_wr && reg_addr == REG_COUNTER) begin
      counter_ff <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // flag word
  // ----------------------------------------------------------------
  // loop branches never touch N C Z V here
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_word_ff <= FLAGS_RESET;
    end else if (kind == OP_IRQ_ON) begin
      flag_word_ff[FLAG_GIE_BIT] <= 1'b1;
    end else if (kind == OP_IRQ_OFF) begin
      flag_word_ff[FLAG_GIE_BIT] <= 1'b0;
    end else if (kind == OP_FIELD_SWAP) begin
      // counter bits go into the chosen field
      if (swap_sel) begin
        flag_word_ff[FLD1_LSB +: FINFO_W] <= counter_ff[FINFO_W-1:0];
      end else begin
        flag_word_ff[FLD0_LSB +: FINFO_W] <= counter_ff[FINFO_W-1:0];
      end
    end else if (reg_wr && reg_addr == REG_FLAGS) begin
      flag_word_ff <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // branch result and debug mode
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      jump_taken_ff <= 1'b0;
      jump_target_ff <= '0;
    end else if (issue) begin
      jump_taken_ff <= taken;
      jump_target_ff <= taken ? cif.target : pc_next;
    end
  end

  // debug mode entered only when permitted; flags left as they were
  always_ff @(posedge clock) begin
    if (rst) begin
      debug_mode_ff <= 1'b0;
    end else if (debug_enter) begin
      debug_mode_ff <= 1'b1;
    end else if (debug_release) begin
      debug_mode_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_s1_ff <= '0;
      irq_s2_ff <= '0;
      irq_s3_ff <= '0;
      irq_level_ff <= '0;
    end else begin
      irq_s1_ff <= irq_src;
      irq_s2_ff <= irq_s1_ff;
      irq_s3_ff <= irq_s2_ff;
      irq_level_ff <= (irq_s2_ff & irq_s3_ff) | (irq_level_ff & (irq_s2_ff | irq_s3_ff));
    end
  end

  // mask bit and global enable both required
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_request_ff <= 1'b0;
    end else begin
      irq_request_ff <= flag_word_ff[FLAG_GIE_BIT] && |(irq_level_ff & irq_mask_ff[IRQ_N-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_mask_ff <= '0;
    end else if (reg_wr && reg_addr == REG_MASK) begin
      irq_mask_ff <= reg_wdata;
    end
  end

  // data only in the cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (rst || !reg_rd) begin
      reg_rdata_ff <= '0;
    end else begin
      unique case (reg_addr)
        REG_FLAGS: reg_rdata_ff <= flag_word_ff;
        REG_COUNTER: reg_rdata_ff <= counter_ff;
        REG_MASK: reg_rdata_ff <= irq_mask_ff;
        REG_EXEC: reg_rdata_ff <= {29'h0, debug_mode_ff, cif.busy, jump_taken_ff};
        default: reg_rdata_ff <= '0;
      endcase
    end
  end

  assign op_busy = cif.busy;
  assign op_done = cif.done;
  assign jump_taken = jump_taken_ff;
  assign jump_target = jump_target_ff;
  assign debug_mode = debug_mode_ff;
  assign irq_request = irq_request_ff;
  assign reg_rdata = reg_rdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_zset_skip: assert property (
    kind == OP_DEC_ZSET && !flag_word_ff[FLAG_Z_BIT] |=> counter_ff == $past(counter_ff)
      && !jump_taken_ff) else $error("zero-set form changed counter with Z clear");
  a_zclr_skip: assert property (
    kind == OP_DEC_ZCLR && flag_word_ff[FLAG_Z_BIT] |=> counter_ff == $past(counter_ff)
      && !jump_taken_ff) else $error("zero-clear form changed counter with Z set");
  a_short_decrement: assert property (
    kind == OP_DEC_SHORT |=> counter_ff == $past(counter_ff) - 32'h0000_0001
      && jump_taken_ff == (counter_ff != '0)) else $error("short form decrement wrong");
  a_long_target: assert property (
    kind == OP_DEC_LONG && taken |=> jump_target_ff == $past(pc_next)
      + {{12{$past(op_ext[15])}}, $past(op_ext), 4'h0}) else $error("long target wrong");
  a_loop_timing: assert property (
    is_loop && taken |=> !cif.done [*2] ##1 cif.done && jump_taken_ff)
    else $error("taken loop branch not three states");
  a_loop_flags: assert property (
    is_loop |=> flag_word_ff[WORD_W-1:FLAG_NCZV_LSB]
      == $past(flag_word_ff[WORD_W-1:FLAG_NCZV_LSB]))
    else $error("loop branch altered flags");
  a_irq_on_word: assert property (
    kind == OP_IRQ_ON |=> flag_word_ff == ($past(flag_word_ff) | 32'h0020_0000) ##2 cif.done)
    else $error("interrupt-on effect or timing wrong");
  a_irq_gate: assert property (
    irq_request_ff |-> $past(flag_word_ff[FLAG_GIE_BIT])
      && $past(|(irq_level_ff & irq_mask_ff[IRQ_N-1:0])))
    else $error("interrupt request without enable and mask");
  a_debug_time: assert property (
    kind == OP_DEBUG && !debug_enter |-> ##8 cif.done) else $error("debug entry not eight states");
  a_swap_counter: assert property (
    kind == OP_FIELD_SWAP |=> counter_ff == {26'h0, $past(old_info)})
    else $error("field swap counter result wrong");

endmodule : lbf_exec_core

// *** test/tb_lbf_exec_core.sv ***
// self-checking bench for the loop, interrupt-enable, debug and field swap unit
// assumes lbf_pkg and lbf_exec_core compiled first; one 10 MHz clock, sync reset
`timescale 1ns/100ps
module tb_lbf_exec_core import lbf_pkg::*;;
  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] PC = 32'h0010_0000;
  localparam logic [WORD_W-1:0] ZF = 32'h2000_0000;
  typedef struct {
    logic [15:0] w;
    logic [15:0] x;
    logic [WORD_W-1:0] c, f, xc, xf;
    logic xt;
    logic [WORD_W-1:0] xg;
    int st;
  } lbf_row_t;
  logic clock, rst, op_valid, op_busy, op_done, jump_taken;
  logic debug_permit, debug_release, debug_mode, irq_request, reg_wr, reg_rd;
  logic [15:0] op_word, irq_src;
  logic [LONG_OFF_W-1:0] op_ext;
  logic [WORD_W-1:0] pc_next, jump_target, reg_wdata, reg_rdata;
  logic [ADDR_W-1:0] reg_addr;
  int n_errors, samples_checked, n;
  lbf_row_t rows [14] = '{
    '{16'h0D80, 16'h7FFF, 32'h9, 32'h0, 32'h8, 32'h0, 1'b1, 32'h0017_FFF0, 3},
    '{16'h0D80, 16'h8000, 32'h1, 32'h0, 32'h0, 32'h0, 1'b0, PC, 2},
    '{16'h0D80, 16'h8000, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1, 32'h0008_0000, 3},
    '{16'h0DA0, 16'hFFFF, 32'h9, ZF, 32'h8, ZF, 1'b1, 32'h000F_FFF0, 3},
    '{16'h0DA0, 16'hFFFF, 32'h9, 32'h0, 32'h9, 32'h0, 1'b0, PC, 2},
    '{16'h0DC0, 16'h0001, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1, 32'h0010_0010, 3},
    '{16'h0DC0, 16'h0001, 32'h1, ZF, 32'h1, ZF, 1'b0, PC, 2},
    '{16'h3BE0, 16'h0000, 32'h9, 32'h0, 32'h8, 32'h0, 1'b1, 32'h0010_01F0, 3},
    '{16'h3FE0, 16'h0000, 32'h2, 32'h0, 32'h1, 32'h0, 1'b1, 32'h000F_FE10, 3},
    '{16'h3C20, 16'h0000, 32'h1, 32'h0, 32'h0, 32'h0, 1'b0, PC, 2},
    '{16'h0D60, 16'h0000, 32'h7, 32'h10, 32'h7, 32'h0020_0010, 1'b0, PC, 3},
    '{16'h0360, 16'h0000, 32'h7, 32'h0020_0010, 32'h7, 32'h10, 1'b0, PC, 3},
    '{16'hD500, 16'h0000, 32'hFFFF_FFC0, 32'hF000_0FFF, 32'h3F, 32'hF000_0FC0, 1'b0, PC, 1},
    '{16'hD700, 16'h0000, 32'hFFFF_FFC0, 32'hF000_0FFF, 32'h3F, 32'hF000_003F, 1'b0, PC, 2}
  };

  lbf_exec_core #(.IRQ_N(16), .DEBUG_EXTRA(4'h4)) i_lbf_exec_core (
    .clock(clock), .rst(rst), .op_valid(op_valid), .op_word(op_word), .op_ext(op_ext),
    .pc_next(pc_next), .op_busy(op_busy), .op_done(op_done), .jump_taken(jump_taken),
    .jump_target(jump_target), .debug_permit(debug_permit), .debug_release(debug_release),
    .debug_mode(debug_mode), .irq_src(irq_src), .irq_request(irq_request),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, e);
  endtask : rd

  // counts cycles from the taking edge to the done pulse, bounded
  task automatic issue(input logic [15:0] w, input logic [15:0] x, output int cnt);
    @(posedge clock);
    op_valid <= 1'b1;
    op_word <= w;
    op_ext <= x;
    @(posedge clock);
    op_valid <= 1'b0;
    cnt = 0;
    do begin
      @(negedge clock);
      cnt++;
    end while (op_done !== 1'b1 && cnt < 40);
  endtask : issue

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs well under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    op_valid = 1'b0;
    op_word = 16'h0000;
    op_ext = 16'h0000;
    pc_next = PC;
    debug_permit = 1'b0;
    debug_release = 1'b0;
    irq_src = 16'h0000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(REG_FLAGS, FLAGS_RESET);
    rd(REG_COUNTER, COUNTER_RESET);
    rd(REG_MASK, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0);
    // table: loop branches, enable on/off and both field swaps
    for (int i = 0; i < 14; i++) begin
      wr(REG_FLAGS, rows[i].f);
      wr(REG_COUNTER, rows[i].c);
      issue(rows[i].w, rows[i].x, n);
      chk(32'(n), 32'(rows[i].st));
      chk({31'h0, jump_taken}, {31'h0, rows[i].xt});
      chk(jump_target, rows[i].xg);
      rd(REG_COUNTER, rows[i].xc);
      rd(REG_FLAGS, rows[i].xf);
    end
    // a word offered while busy is dropped, so only one decrement lands
    wr(REG_COUNTER, 32'h5);
    @(posedge clock);
    op_valid <= 1'b1;
    op_word <= 16'h0D80;
    op_ext <= 16'h0001;
    @(posedge clock);
    @(negedge clock);
    chk({31'h0, op_busy}, 32'h1);
    @(posedge clock);
    op_valid <= 1'b0;
    repeat (6) @(posedge clock);
    rd(REG_COUNTER, 32'h4);
    // interrupt gating by global enable and mask
    wr(REG_FLAGS, 32'h0);
    wr(REG_MASK, 32'h1);
    @(posedge clock);
    irq_src <= 16'h0001;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk({31'h0, irq_request}, 32'h0);
    issue(16'h0D60, 16'h0000, n);
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk({31'h0, irq_request}, 32'h1);
    @(posedge clock);
    irq_src <= 16'h0002;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk({31'h0, irq_request}, 32'h0);
    @(posedge clock);
    irq_src <= 16'h0001;
    issue(16'h0360, 16'h0000, n);
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk({31'h0, irq_request}, 32'h0);
    // debug entry refused, then entered with extra states
    issue(16'h0100, 16'h0000, n);
    chk(32'(n), 32'(MS_DEBUG));
    chk({31'h0, debug_mode}, 32'h0);
    @(posedge clock);
    debug_permit <= 1'b1;
    issue(16'h0100, 16'h0000, n);
    chk(32'(n), 32'(MS_DEBUG) + 32'h4);
    chk({31'h0, debug_mode}, 32'h1);
    rd(REG_EXEC, 32'h0000_0004);
    @(posedge clock);
    debug_permit <= 1'b0;
    debug_release <= 1'b1;
    @(posedge clock);
    debug_release <= 1'b0;
    @(negedge clock);
    chk({31'h0, debug_mode}, 32'h0);
    // second reset in mid-run
    wr(REG_COUNTER, 32'h1234_5678);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(REG_COUNTER, COUNTER_RESET);
    rd(REG_MASK, 32'h0);
    stop_test();
  end
endmodule : tb_lbf_exec_core
